// ---- smcp_front.sv ----
// SPI slave command front end with status register and write protection
`timescale 1ns/1ps
`default_nettype none
`include "smcp_cfg.svh"
module smcp_front (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Serial pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    output logic miso_o,
    output logic miso_oe,
    input wire logic protect_pin_n,
    // Array side
    output smcp_pkg::smcp_wr_t mem_wr,
    output logic [17:0] mem_rd_addr,
    output smcp_pkg::smcp_cmd_t active_cmd,
    output logic [7:0] protection_status
);
    typedef struct packed {
        smcp_pkg::smcp_state_t fsm;
        smcp_pkg::smcp_cmd_t cmd;
        logic mode3;
        logic armed;
        logic [2:0] bitcnt;
        logic [1:0] bytecnt;
        logic [7:0] shift_in;
        logic [7:0] shift_out;
        logic [23:0] addr;
        logic out_en;
        logic out_bit;
        logic latch;
        logic bp_lo;
        logic bp_hi;
        logic pin_en;
        logic [17:0] wr_addr;
        logic halted;
        smcp_pkg::smcp_wr_t wr;
    } smcp_front_state_t;

    smcp_front_state_t st;
    smcp_front_state_t next_st;
    smcp_pkg::smcp_pins_t pins; // Conditioned pins
    logic status_write_ok; // Status write allowed now
    logic array_write_ok; // Array write allowed at wr_addr
    logic [7:0] status_view; // Assembled status byte
    logic [7:0] byte_in; // Byte completing on this edge
    logic sample; // Rising edge counted as a data sample

    // Opcode decode, used at opcode completion
    function automatic smcp_pkg::smcp_cmd_t decode_op(input logic [7:0] op);
        case (op)
            `SMCP_OP_LATCH_SET: decode_op = smcp_pkg::SMCP_CMD_LATCH_SET;
            `SMCP_OP_LATCH_CLEAR: decode_op = smcp_pkg::SMCP_CMD_LATCH_CLEAR;
            `SMCP_OP_STATUS_READ: decode_op = smcp_pkg::SMCP_CMD_STATUS_READ;
            `SMCP_OP_STATUS_WRITE: decode_op = smcp_pkg::SMCP_CMD_STATUS_WRITE;
            `SMCP_OP_MEM_READ: decode_op = smcp_pkg::SMCP_CMD_MEM_READ;
            `SMCP_OP_FAST_READ: decode_op = smcp_pkg::SMCP_CMD_FAST_READ;
            `SMCP_OP_MEM_WRITE: decode_op = smcp_pkg::SMCP_CMD_MEM_WRITE;
            `SMCP_OP_SLEEP: decode_op = smcp_pkg::SMCP_CMD_SLEEP;
            `SMCP_OP_IDENT_READ: decode_op = smcp_pkg::SMCP_CMD_IDENT_READ;
            default: decode_op = smcp_pkg::SMCP_CMD_INVALID;
        endcase
    endfunction

    // Pin conditioning
    smcp_pin_sync u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .cs_n(cs_n),
        .sck(sck),
        .mosi(mosi),
        .protect_pin_n(protect_pin_n),
        .pins(pins)
    );

    // Permission decode
    smcp_protect u_prot (
        .write_enable_latch(st.latch),
        .block_protect_lo(st.bp_lo),
        .block_protect_hi(st.bp_hi),
        .protect_pin_enable(st.pin_en),
        .protect_pin_n(pins.protect_pin_n),
        .addr(st.wr_addr),
        .status_write_ok(status_write_ok),
        .array_write_ok(array_write_ok)
    );

    // Status byte: fixed positions are constants, never stored
    always_comb begin
        status_view = `SMCP_SR_FIXED_ONE;
        status_view[`SMCP_SR_PEN_BIT] = st.pin_en;
        status_view[`SMCP_SR_BP_HI_BIT] = st.bp_hi;
        status_view[`SMCP_SR_BP_LO_BIT] = st.bp_lo;
        status_view[`SMCP_SR_WEL_BIT] = st.latch;
    end

    // In mode 3 the idle-high level is not an edge; armed after a fall
    assign sample = pins.sel && pins.sck_rise && st.armed;
    assign byte_in = {st.shift_in[6:0], pins.mosi}; // MSB first

    // Next-state logic for the whole front end
    always_comb begin
        next_st = st;
        next_st.wr.valid = 1'b0;
        if (pins.sel_fall) begin
            // New command frame; mode from clock level
            next_st.fsm = smcp_pkg::SMCP_ST_OPCODE;
            next_st.cmd = smcp_pkg::SMCP_CMD_NONE;
            next_st.mode3 = pins.sck_level;
            next_st.armed = !pins.sck_level;
            next_st.bitcnt = 3'h0;
            next_st.bytecnt = 2'h0;
            next_st.out_en = 1'b0;
            next_st.halted = 1'b0;
        end else if (!pins.sel) begin
            // Deselected: input ignored, output released
            next_st.out_en = 1'b0;
            if (pins.sel_rise) begin
                // Clearing commands take effect at the frame end
                if (st.cmd == smcp_pkg::SMCP_CMD_LATCH_CLEAR ||
                    st.cmd == smcp_pkg::SMCP_CMD_STATUS_WRITE ||
                    st.cmd == smcp_pkg::SMCP_CMD_MEM_WRITE) begin
                    next_st.latch = 1'b0;
                end else if (st.cmd == smcp_pkg::SMCP_CMD_LATCH_SET) begin
                    next_st.latch = 1'b1;
                end
                next_st.cmd = smcp_pkg::SMCP_CMD_NONE;
            end
            next_st.fsm = smcp_pkg::SMCP_ST_IDLE;
        end else begin
            if (pins.sck_fall) begin
                next_st.armed = 1'b1;
                if (st.fsm == smcp_pkg::SMCP_ST_STATUS_OUT) begin
                    // Drive on falling edges, MSB first
                    next_st.out_en = 1'b1;
                    next_st.out_bit = st.shift_out[7];
                    next_st.shift_out = {st.shift_out[6:0], 1'b0};
                end
            end
            if (sample) begin
                next_st.shift_in = byte_in;
                next_st.bitcnt = st.bitcnt + 3'h1;
                if (st.bitcnt == 3'h7) begin
                    case (st.fsm)
                        smcp_pkg::SMCP_ST_OPCODE: begin
                            // First byte is the opcode
                            next_st.cmd = decode_op(byte_in);
                            case (decode_op(byte_in))
                                smcp_pkg::SMCP_CMD_STATUS_READ: begin
                                    next_st.fsm = smcp_pkg::SMCP_ST_STATUS_OUT;
                                    next_st.shift_out = status_view;
                                end
                                smcp_pkg::SMCP_CMD_STATUS_WRITE:
                                    next_st.fsm = smcp_pkg::SMCP_ST_STATUS_IN;
                                smcp_pkg::SMCP_CMD_MEM_READ,
                                smcp_pkg::SMCP_CMD_FAST_READ,
                                smcp_pkg::SMCP_CMD_MEM_WRITE:
                                    next_st.fsm = smcp_pkg::SMCP_ST_ADDR;
                                // Unknown byte: nothing more this frame
                                smcp_pkg::SMCP_CMD_INVALID:
                                    next_st.fsm = smcp_pkg::SMCP_ST_IGNORE;
                                default:
                                    next_st.fsm = smcp_pkg::SMCP_ST_PASS;
                            endcase
                        end
                        smcp_pkg::SMCP_ST_ADDR: begin
                            next_st.addr = {st.addr[15:0], byte_in};
                            next_st.bytecnt = st.bytecnt + 2'h1;
                            if (st.bytecnt == 2'h2) begin
                                // Top six bits dropped
                                next_st.wr_addr = {st.addr[9:0], byte_in};
                                next_st.fsm = smcp_pkg::SMCP_ST_DATA;
                            end
                        end
                        smcp_pkg::SMCP_ST_DATA: begin
                            if (st.cmd == smcp_pkg::SMCP_CMD_MEM_WRITE &&
                                !st.halted) begin
                                if (array_write_ok) begin
                                    // Accepted byte goes to the array
                                    next_st.wr.valid = 1'b1;
                                    next_st.wr.addr = st.wr_addr;
                                    next_st.wr.data = byte_in;
                                    next_st.wr_addr = st.wr_addr + 18'h00001;
                                end else begin
                                    // Protected block stops the burst
                                    next_st.halted = 1'b1;
                                end
                            end
                        end
                        smcp_pkg::SMCP_ST_STATUS_IN: begin
                            // Whole byte only, latch untouched
                            if (status_write_ok) begin
                                next_st.pin_en = byte_in[`SMCP_SR_PEN_BIT];
                                next_st.bp_hi = byte_in[`SMCP_SR_BP_HI_BIT];
                                next_st.bp_lo = byte_in[`SMCP_SR_BP_LO_BIT];
                            end
                            next_st.fsm = smcp_pkg::SMCP_ST_PASS;
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // State register; latch and protection clear at power-up
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs, all from flip-flops
    assign miso_o = st.out_bit;
    assign miso_oe = st.out_en && pins.sel;
    assign mem_wr = st.wr;
    assign mem_rd_addr = st.wr_addr;
    assign active_cmd = st.cmd;
    assign protection_status = status_view;

    // Checks: latch behaviour at the frame ends
    a_latch_reset: assert property (@(posedge clk) disable iff (!arst_n)
        (pins.sel_rise && st.cmd == smcp_pkg::SMCP_CMD_LATCH_CLEAR)
        |=> !st.latch) else $error("latch not cleared");
    a_latch_set: assert property (@(posedge clk) disable iff (!arst_n)
        (pins.sel_rise && st.cmd == smcp_pkg::SMCP_CMD_LATCH_SET)
        |=> st.latch) else $error("latch not set");
    a_wrend_clear: assert property (@(posedge clk) disable iff (!arst_n)
        (pins.sel_rise && (st.cmd == smcp_pkg::SMCP_CMD_MEM_WRITE ||
        st.cmd == smcp_pkg::SMCP_CMD_STATUS_WRITE))
        |=> !st.latch) else $error("latch kept after write");
    // Status byte and output enable
    a_fixed_bits: assert property (@(posedge clk) disable iff (!arst_n)
        (protection_status & 8'h71) == 8'h40)
        else $error("fixed status bits wrong");
    a_idle_tristate: assert property (@(posedge clk) disable iff (!arst_n)
        !pins.sel |-> !miso_oe) else $error("driving while idle");
    a_invalid_quiet: assert property (@(posedge clk) disable iff (!arst_n)
        st.fsm == smcp_pkg::SMCP_ST_IGNORE |-> !miso_oe && !mem_wr.valid)
        else $error("activity after bad opcode");
    // Write permission
    a_wr_needs_latch: assert property (@(posedge clk) disable iff (!arst_n)
        mem_wr.valid |-> $past(st.latch)) else $error("write w/o latch");
    a_sr_pin_block: assert property (@(posedge clk) disable iff (!arst_n)
        (st.pin_en && !pins.protect_pin_n && $stable(pins.protect_pin_n))
        |=> $stable({st.bp_hi, st.bp_lo, st.pin_en}))
        else $error("status changed while pin protects");
    a_latch_only_cmds: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(st.latch) |-> $past(st.cmd) == smcp_pkg::SMCP_CMD_LATCH_SET)
        else $error("latch set by other command");
    a_sr_whole_byte: assert property (@(posedge clk) disable iff (!arst_n)
        !(st.fsm == smcp_pkg::SMCP_ST_STATUS_IN && sample &&
        st.bitcnt == 3'h7) |=> $stable({st.bp_hi, st.bp_lo, st.pin_en}))
        else $error("status changed without a whole byte");
    // Mode pick and arming at the select edge, then one opcode per frame
    a_mode3_arm: assert property (@(posedge clk) disable iff (!arst_n)
        (pins.sel_fall && pins.sck_level) |=> (st.mode3 && !st.armed))
        else $error("mode 3 armed at select");
    a_mode0_arm: assert property (@(posedge clk) disable iff (!arst_n)
        (pins.sel_fall && !pins.sck_level) |=> (!st.mode3 && st.armed))
        else $error("mode 0 not armed at select");
    a_one_opcode: assert property (@(posedge clk) disable iff (!arst_n)
        (pins.sel && !pins.sel_fall && st.fsm != smcp_pkg::SMCP_ST_OPCODE)
        |=> $stable(st.cmd)) else $error("second opcode in frame");
    // Covers of the main scenarios
    c_burst_halt: cover property (@(posedge clk) disable iff (!arst_n)
        st.halted && st.cmd == smcp_pkg::SMCP_CMD_MEM_WRITE);
    c_status_read: cover property (@(posedge clk) disable iff (!arst_n)
        st.fsm == smcp_pkg::SMCP_ST_STATUS_OUT && miso_oe);
    c_mem_write: cover property (@(posedge clk) disable iff (!arst_n)
        mem_wr.valid);
    c_mode3: cover property (@(posedge clk) disable iff (!arst_n)
        pins.sel_fall && pins.sck_level);
endmodule // smcp_front
`default_nettype wire

// ---- smcp_cfg.svh ----
// Constants for the SPI memory command and protection front end
`ifndef SMCP_CFG_SVH
`define SMCP_CFG_SVH
`define SMCP_OP_LATCH_SET 8'h06
`define SMCP_OP_LATCH_CLEAR 8'h04
`define SMCP_OP_STATUS_READ 8'h05
`define SMCP_OP_STATUS_WRITE 8'h01
`define SMCP_OP_MEM_READ 8'h03
`define SMCP_OP_FAST_READ 8'h0B
`define SMCP_OP_MEM_WRITE 8'h02
`define SMCP_OP_SLEEP 8'hB9
`define SMCP_OP_IDENT_READ 8'h9F
`define SMCP_SR_WEL_BIT 1
`define SMCP_SR_BP_LO_BIT 2
`define SMCP_SR_BP_HI_BIT 3
`define SMCP_SR_PEN_BIT 7
`define SMCP_SR_FIXED_ONE 8'h40
`define SMCP_SR_RESET 8'h40
`define SMCP_ADDR_BITS 18
`define SMCP_QUARTER_BASE 18'h30000
`define SMCP_HALF_BASE 18'h20000
`define SMCP_WHOLE_BASE 18'h00000
`endif

// ---- smcp_pkg.sv ----
// Types for the SPI memory command and protection front end
`default_nettype none
package smcp_pkg;
    typedef enum logic [3:0] {
        SMCP_ST_IDLE, SMCP_ST_OPCODE, SMCP_ST_ADDR, SMCP_ST_DATA,
        SMCP_ST_STATUS_OUT, SMCP_ST_STATUS_IN, SMCP_ST_PASS, SMCP_ST_IGNORE
    } smcp_state_t;
    typedef enum logic [3:0] {
        SMCP_CMD_NONE, SMCP_CMD_LATCH_SET, SMCP_CMD_LATCH_CLEAR,
        SMCP_CMD_STATUS_READ, SMCP_CMD_STATUS_WRITE, SMCP_CMD_MEM_READ,
        SMCP_CMD_FAST_READ, SMCP_CMD_MEM_WRITE, SMCP_CMD_SLEEP,
        SMCP_CMD_IDENT_READ, SMCP_CMD_INVALID
    } smcp_cmd_t;
    // Synchronised pin samples and their edges
    typedef struct packed {
        logic sel;
        logic sel_fall;
        logic sel_rise;
        logic sck_rise;
        logic sck_fall;
        logic sck_level;
        logic mosi;
        logic protect_pin_n;
    } smcp_pins_t;
    // Memory write request to the array side
    typedef struct packed {
        logic valid;
        logic [17:0] addr;
        logic [7:0] data;
    } smcp_wr_t;
endpackage
`default_nettype wire

// ---- smcp_pin_sync.sv ----
// Two-stage synchronisers and edge detect for the serial pins
`timescale 1ns/1ps
`default_nettype none
module smcp_pin_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Raw pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic protect_pin_n,
    // Conditioned samples
    output smcp_pkg::smcp_pins_t pins
);
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [1:0] last;
    } smcp_sync_state_t;
    smcp_sync_state_t st;
    smcp_sync_state_t next_st;
    // Only s2 and its delayed copy last are read by logic; s1 feeds s2 alone
    always_comb begin
        next_st = st;
        next_st.s1 = {cs_n, sck, mosi, protect_pin_n};
        next_st.s2 = st.s1;
        next_st.last = {st.s2[3], st.s2[2]};
    end
    // Register the whole state; deselected and idle-high after reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '{s1: 4'hF, s2: 4'hF, last: 2'h3};
        end else begin
            st <= next_st;
        end
    end
    // Edges come from the second stage against its own delayed copy
    always_comb begin
        pins.sel = !st.s2[3];
        pins.sel_fall = st.last[1] && !st.s2[3];
        pins.sel_rise = !st.last[1] && st.s2[3];
        pins.sck_rise = !st.last[0] && st.s2[2];
        pins.sck_fall = st.last[0] && !st.s2[2];
        pins.sck_level = st.s2[2];
        pins.mosi = st.s2[1];
        pins.protect_pin_n = st.s2[0];
    end
endmodule // smcp_pin_sync
`default_nettype wire

// ---- smcp_protect.sv ----
// Write permission decode for status register and array
`timescale 1ns/1ps
`default_nettype none
`include "smcp_cfg.svh"
module smcp_protect (
    // Status bits in force
    input wire logic write_enable_latch,
    input wire logic block_protect_lo,
    input wire logic block_protect_hi,
    input wire logic protect_pin_enable,
    input wire logic protect_pin_n,
    // Array address under test
    input wire logic [17:0] addr,
    // Permissions
    output logic status_write_ok,
    output logic array_write_ok
);
    logic in_block;
    // Block protect select; the pin never enters here
    always_comb begin
        case ({block_protect_hi, block_protect_lo})
            2'h1: in_block = addr >= `SMCP_QUARTER_BASE;
            2'h2: in_block = addr >= `SMCP_HALF_BASE;
            2'h3: in_block = addr >= `SMCP_WHOLE_BASE;
            default: in_block = 1'b0;
        endcase
        array_write_ok = write_enable_latch && !in_block;
        // Pin only counts when enabled
        status_write_ok = write_enable_latch &&
            !(protect_pin_enable && !protect_pin_n);
    end
endmodule // smcp_protect
`default_nettype wire

// ---- smcp_master.sv ----
// SPI bus master model that frames commands into the device pins
`timescale 1ns/1ps
`default_nettype none
module smcp_master #(
    parameter int HALF = 8
) (
    // Clock that paces the pins
    input wire logic clk,
    // Serial pins
    output logic cs_n,
    output logic sck,
    output logic mosi,
    input wire logic miso
);
    // Idle bus before the first frame
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
    end

    // Wait n falling clock edges, so pins move away from the sampling edge
    task automatic pace(input int n);
        repeat (n) @(negedge clk);
    endtask

    // One selection period: nb bits out, the line sampled at each rise
    task automatic xfer(input int nb, input logic [47:0] d, input logic m3,
                        output logic [47:0] q);
        q = '0;
        sck = m3; // Idle level before select sets the mode
        pace(HALF);
        cs_n = 1'b0;
        pace(HALF);
        for (int i = nb - 1; i >= 0; i--) begin
            sck = 1'b0; // Device moves its output on this fall
            mosi = d[i]; // Highest bit goes first
            pace(HALF);
            sck = 1'b1; // Device samples on this rise
            q = {q[46:0], miso};
            pace(HALF);
        end
        sck = m3; // Back to the idle level of the mode
        pace(HALF);
        cs_n = 1'b1; // Deselect between commands
        mosi = ~mosi; // Released line must not keep its last level
        pace(4 * HALF);
    endtask
endmodule // smcp_master
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking testbench for the SPI command and protection front end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // One frame, the pin level during it and what should follow
    typedef struct {
        int nb;
        logic [39:0] d;
        logic pin;
        logic [7:0] sr;
        logic [7:0] msk;
        int wr;
        logic [25:0] wd;
    } smcp_row_t;
    logic clk;
    logic arst_n;
    logic protect_pin_n;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    wire logic miso_line;
    smcp_pkg::smcp_wr_t mem_wr;
    logic [17:0] mem_rd_addr;
    smcp_pkg::smcp_cmd_t active_cmd;
    smcp_pkg::smcp_cmd_t last_cmd = smcp_pkg::SMCP_CMD_NONE;
    logic [7:0] protection_status;
    int mismatches = 0;
    int num_checks = 0;
    int wr_n;
    int oe_n;
    logic [25:0] last_wr;
    logic [47:0] q;
    smcp_row_t rows [35];

    // Line level: undriven while output enable is low
    assign miso_line = miso_oe ? miso_o : 1'bz;

    smcp_front dut (
        .clk(clk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .mosi(mosi),
        .miso_o(miso_o), .miso_oe(miso_oe), .protect_pin_n(protect_pin_n),
        .mem_wr(mem_wr), .mem_rd_addr(mem_rd_addr), .active_cmd(active_cmd),
        .protection_status(protection_status)
    );
    smcp_master m (
        .clk(clk), .cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso_line)
    );

    // 50 ns clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Count accepted array bytes and driven output cycles; the falling
    // edge is used so that registered outputs have settled
    always @(negedge clk) begin
        if (active_cmd != smcp_pkg::SMCP_CMD_NONE) begin
            last_cmd = active_cmd;
        end
        if (mem_wr.valid === 1'b1) begin
            wr_n++;
            last_wr = {mem_wr.addr, mem_wr.data};
        end
        if (miso_oe === 1'b1) begin
            oe_n++;
        end
    end

    // Compare and report at once
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s seen %h expected %h", $time, what, seen,
                     exp);
        end
    endtask

    // Single exit of the run
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog: the tests need about 14,000 cycles, this allows 50,000
    initial begin
        #2_500_000;
        mismatches++;
        stop_test();
    end

    // Main sequence
    initial begin
        arst_n = 1'b0;
        protect_pin_n = 1'b1;
        rows = '{
            '{8, 40'h06, 1'b1, 8'h42, 8'hFF, 0, 26'h0},
            '{16, 40'h0500, 1'b1, 8'h42, 8'hFF, 0, 26'h0},
            '{8, 40'h04, 1'b1, 8'h40, 8'hFF, 0, 26'h0},
            '{16, 40'h01FF, 1'b1, 8'h40, 8'hFF, 0, 26'h0},
            '{40, 40'h0200000011, 1'b1, 8'h40, 8'hFF, 0, 26'h0},
            '{8, 40'h06, 1'b1, 8'h42, 8'hFF, 0, 26'h0},
            '{16, 40'h01FF, 1'b1, 8'hCC, 8'hFF, 0, 26'h0},
            '{16, 40'h0500, 1'b1, 8'hCC, 8'hFF, 0, 26'h0},
            '{8, 40'h06, 1'b1, 8'hCE, 8'hFF, 0, 26'h0},
            '{12, 40'h010, 1'b1, 8'hCC, 8'hFF, 0, 26'h0},
            '{8, 40'h06, 1'b1, 8'hCE, 8'hFF, 0, 26'h0},
            '{16, 40'h0104, 1'b0, 8'hCC, 8'hFF, 0, 26'h0},
            '{8, 40'h06, 1'b1, 8'hCE, 8'hFF, 0, 26'h0},
            '{16, 40'h0104, 1'b1, 8'h44, 8'hFF, 0, 26'h0},
            '{8, 40'h06, 1'b1, 8'h46, 8'hFF, 0, 26'h0},
            '{40, 40'h02030000A5, 1'b1, 8'h44, 8'hFF, 0, 26'h0},
            '{8, 40'h06, 1'b1, 8'h46, 8'hFF, 0, 26'h0},
            '{40, 40'h02FEFFFF3C, 1'b1, 8'h44, 8'hFF, 1, {18'h2FFFF, 8'h3C}},
            '{8, 40'h06, 1'b1, 8'h46, 8'hFF, 0, 26'h0},
            '{16, 40'h0188, 1'b1, 8'hC8, 8'hFF, 0, 26'h0},
            '{8, 40'h06, 1'b1, 8'hCA, 8'hFF, 0, 26'h0},
            '{40, 40'h0201FFFF5A, 1'b0, 8'hC8, 8'hFF, 1, {18'h1FFFF, 8'h5A}},
            '{8, 40'h06, 1'b1, 8'hCA, 8'hFF, 0, 26'h0},
            '{40, 40'h0202000066, 1'b1, 8'hC8, 8'hFF, 0, 26'h0},
            '{8, 40'h06, 1'b1, 8'hCA, 8'hFF, 0, 26'h0},
            '{16, 40'h010C, 1'b1, 8'h4C, 8'hFF, 0, 26'h0},
            '{8, 40'h06, 1'b1, 8'h4E, 8'hFF, 0, 26'h0},
            '{40, 40'h0200000077, 1'b1, 8'h4C, 8'hFF, 0, 26'h0},
            '{8, 40'h0B, 1'b1, 8'h4C, 8'hFF, 0, 26'h0},
            '{8, 40'hB9, 1'b1, 8'h4C, 8'hFF, 0, 26'h0},
            '{8, 40'h9F, 1'b1, 8'h4C, 8'hFF, 0, 26'h0},
            '{8, 40'h03, 1'b1, 8'h4C, 8'hFF, 0, 26'h0},
            '{16, 40'hFF06, 1'b1, 8'h4C, 8'hFF, 0, 26'h0},
            '{8, 40'h06, 1'b1, 8'h4E, 8'hFF, 0, 26'h0},
            '{16, 40'h0100, 1'b1, 8'h40, 8'hFF, 0, 26'h0}
        };
        repeat (8) @(negedge clk);
        // Reset values before any command
        check(protection_status, 8'h40, "reset status");
        check(miso_oe, 1'b0, "reset output enable");
        arst_n = 1'b1;
        m.pace(4);
        // Table rows, mode alternating between 0 and 3
        foreach (rows[i]) begin
            wr_n = 0;
            oe_n = 0;
            protect_pin_n = rows[i].pin;
            m.xfer(rows[i].nb, {8'h00, rows[i].d}, i[0], q);
            check(protection_status & rows[i].msk, rows[i].sr & rows[i].msk,
                  "status");
            check(wr_n, rows[i].wr, "array writes");
            if (rows[i].wr > 0) begin
                check(last_wr, rows[i].wd, "write address data");
            end
            if (rows[i].nb == 16 && rows[i].d[15:8] == 8'h05) begin
                check(q[7:0], rows[i].sr, "status read");
            end else begin
                check(oe_n, 0, "output driven");
            end
            $display("row %0d done", i);
        end
        // Reset in mid-run drops a set latch
        m.xfer(8, 48'h06, 1'b0, q);
        arst_n = 1'b0;
        m.pace(2);
        check(protection_status, 8'h40, "mid-run reset");
        check(miso_oe, 1'b0, "mid-run reset output");
        arst_n = 1'b1;
        m.pace(4);
        // Status read answers again after the reset, in mode 3
        m.xfer(16, 48'h0500, 1'b1, q);
        check(q[7:0], 8'h40, "read after reset");
        $display("mid-run reset done");
        // Two-byte burst lands at consecutive addresses
        wr_n = 0;
        m.xfer(8, 48'h06, 1'b0, q);
        m.xfer(48, 48'h0200_0010_AABB, 1'b1, q);
        check(wr_n, 2, "burst writes");
        check(last_wr, {18'h00011, 8'hBB}, "burst last byte");
        check(mem_rd_addr, 18'h00012, "burst next address");
        check(last_cmd, smcp_pkg::SMCP_CMD_MEM_WRITE, "decoded");
        // Burst running into the protected upper quarter stops there
        m.xfer(8, 48'h06, 1'b0, q);
        m.xfer(16, 48'h0104, 1'b1, q);
        check(protection_status, 8'h44, "quarter protect set");
        wr_n = 0;
        m.xfer(8, 48'h06, 1'b0, q);
        m.xfer(48, 48'h0202_FFFF_1122, 1'b1, q);
        check(wr_n, 1, "halted burst writes");
        check(last_wr, {18'h2FFFF, 8'h11}, "halted burst byte");
        check(mem_rd_addr, 18'h30000, "halted burst address");
        $display("burst tests done");
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
